/* rtl/occ_defines.svh */
// Summary of operation
// - Each output selects normal or low-power mode with an eight-level amplitude.
// - Single-ended pins default to opposite polarity; an option drives them in phase.
// - Active-low enable pin high disables all outputs; low permits them.
// - Each output can also be disabled by its own register bit.
// - Each disabled output holds low or high, chosen per output.
// - Each output picks synchronous or asynchronous disable; synchronous after reset.
// - Synchronous disable waits for the current period to end, no runt pulse.
// - Asynchronous disable stops the output at once.
// - Crosspoint routes any of five dividers to any of ten outputs.
// - Outputs start phase aligned; each divider has a programmable skew delay.
// - Host writes skew, then soft reset; device applies skew and realigns.
// - Hard reset reloads every skew setting from its nonvolatile default.
// - Zero delay mode opens internal feedback and uses the external input.
// - Hard reset pin or bit reloads all output dividers to default state.
// - Rising edge on realign pin realigns output dividers without device reset.
// - Realign register bit does the same as a realign pin edge.
// - Soft reset realigns outputs to the positions given by skew settings.
// - Divider frequency changes are glitch-free on all outputs routed from it.
// - Each divider holds a 44-bit step word; up/down requests step frequency.
// - Step word is fine-grained and set independently per divider.
// - New numerator takes effect only after numerator and update bit are written.
// - Numerator can be shifted so one LSB equals the needed step.
// - Hard reset reloads all registers; soft reset only applies changes.
`ifndef OCC_DEFINES_SVH
`define OCC_DEFINES_SVH

// Global register byte addresses
`define OCC_A_CTRL      9'h000
`define OCC_A_OUT_EN    9'h004
`define OCC_A_DIS_LVL   9'h008
`define OCC_A_ASYNC     9'h00C
`define OCC_A_INPHASE   9'h010
`define OCC_A_STATUS    9'h014
`define OCC_A_XSEL      9'h018
`define OCC_A_DRV_MODE  9'h01C
`define OCC_A_DRV_AMP   9'h020
// Per-divider block: base 0x100, stride 0x20, offsets below
`define OCC_O_NUM       5'h00
`define OCC_O_NUM_UPD   5'h04
`define OCC_O_STEP_LO   5'h08
`define OCC_O_STEP_HI   5'h0C
`define OCC_O_SKEW      5'h10
`define OCC_O_FREQ_CTL  5'h14
`define OCC_O_SHIFT     5'h18
`define OCC_O_FREQ_RB   5'h1C
// Control bit positions
`define OCC_B_SOFT      0
`define OCC_B_HARD      1
`define OCC_B_REALIGN   2
`define OCC_B_ZDM       3
// Reset and nonvolatile default values
`define OCC_OUT_EN_RST  10'h3FF
`define OCC_XSEL_RST    30'h0000_0000
`define OCC_AMP_RST     30'h1249_2492
`define OCC_NUM_RST     32'h4000_0000
`define OCC_SHIFT_RST   4'h4
`define OCC_FREQ_RST    44'h004_0000_0000
`define OCC_SKEW_NV     16'h0000
`define OCC_NDIV        5
`define OCC_NOUT        10

`endif

/* rtl/occ_pkg.sv */
package occ_pkg;
    typedef enum logic {BUS_IDLE, BUS_ACK} occ_bus_e;
    typedef logic [43:0] occ_word_t;
endpackage : occ_pkg

/* rtl/occ_top.sv */
// The address map and the Avalon-MM register port were decided locally.
`include "occ_defines.svh"

module occ_top (
    // Clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   reset,
    // Avalon-MM slave
    input  wire logic [8:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    // Host pins
    input  wire logic                   oe_n,
    input  wire logic                   sync_pin,
    input  wire logic [4:0]             freq_up_request,
    input  wire logic [4:0]             freq_down_request,
    input  wire logic                   external_feedback_input,
    // Clock outputs and driver settings
    output logic      [9:0]             out_p,
    output logic      [9:0]             out_n,
    output logic      [9:0]             drv_low_power,
    output logic      [29:0]            drv_amplitude,
    output logic                        feedback_external,
    output occ_pkg::occ_word_t          div_freq_word_0
);
    import occ_pkg::*;

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : be_merge

    // Bus slave: one wait cycle, answer in the second cycle
    occ_bus_e    bus_state_reg;
    logic        waitreq_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rd_mux;

    assign avs_waitrequest = waitreq_reg;
    assign avs_readdata    = rdata_reg;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bus_state_reg <= BUS_IDLE;
            waitreq_reg   <= 1'b1;
            rdata_reg     <= 32'h0000_0000;
        end else begin
            case (bus_state_reg)
                BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state_reg <= BUS_ACK;
                        waitreq_reg   <= 1'b0;
                        rdata_reg     <= avs_read ? rd_mux : 32'h0000_0000;
                    end
                end
                default: begin
                    bus_state_reg <= BUS_IDLE;
                    waitreq_reg   <= 1'b1;
                    rdata_reg     <= 32'h0000_0000;
                end
            endcase
        end
    end

    wire       wr_fire  = avs_write && (bus_state_reg == BUS_ACK);
    wire       div_hit  = avs_address[8] && (avs_address[7:5] < 3'h5);
    wire [2:0] div_idx  = avs_address[7:5];
    wire [4:0] div_off  = avs_address[4:0];
    wire       wr_g     = wr_fire && !avs_address[8];
    wire       wr_ctl   = wr_g && (avs_address == `OCC_A_CTRL);
    wire       ctl_b0   = wr_ctl && avs_byteenable[0];

    // Pin synchronizers: s1 feeds only s2; s3 is for edge detection
    logic [12:0] pin_s1_reg;
    logic [12:0] pin_s2_reg;
    logic [12:0] pin_s3_reg;
    wire  [12:0] pin_raw = {external_feedback_input, oe_n, sync_pin,
                            freq_up_request, freq_down_request};

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_s1_reg <= 13'h0000;
            pin_s2_reg <= 13'h0000;
            pin_s3_reg <= 13'h0000;
        end else begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    wire [12:0] pin_rise  = pin_s2_reg & ~pin_s3_reg;
    wire [4:0]  down_edge = pin_rise[4:0];
    wire [4:0]  up_edge   = pin_rise[9:5];
    wire        sync_edge = pin_rise[10];
    wire        oe_n_lvl  = pin_s2_reg[11];
    wire        ext_fb    = pin_s2_reg[12];

    // Reset pulses from the control register
    logic hard_reg;
    logic soft_reg;
    logic realign_reg;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            hard_reg    <= 1'b0;
            soft_reg    <= 1'b0;
            realign_reg <= 1'b0;
        end else begin
            hard_reg    <= ctl_b0 && avs_writedata[`OCC_B_HARD];
            soft_reg    <= ctl_b0 && avs_writedata[`OCC_B_SOFT];
            realign_reg <= ctl_b0 && avs_writedata[`OCC_B_REALIGN];
        end
    end

    wire cfg_rst     = reset || hard_reg;
    wire realign_evt = realign_reg || sync_edge;

    // Global configuration
    logic [9:0]  out_en_reg;
    logic [9:0]  dis_lvl_reg;
    logic [9:0]  async_reg;
    logic [9:0]  inphase_reg;
    logic [29:0] xsel_reg;
    logic [9:0]  mode_reg;
    logic [29:0] amp_reg;
    logic        zdm_reg;

    wire [31:0] wd = avs_writedata;
    wire [3:0]  be = avs_byteenable;
    // Read mux supplies the old word, so byte lanes merge in one place
    wire [31:0] wr_mrg = be_merge(rd_mux, wd, be);

    always_ff @(posedge clk_sys) begin
        if (cfg_rst) begin
            out_en_reg  <= `OCC_OUT_EN_RST;
            dis_lvl_reg <= 10'h000;
            async_reg   <= 10'h000;
            inphase_reg <= 10'h000;
            xsel_reg    <= `OCC_XSEL_RST;
            mode_reg    <= 10'h000;
            amp_reg     <= `OCC_AMP_RST;
            zdm_reg     <= 1'b0;
        end else if (wr_g) begin
            case (avs_address)
                `OCC_A_CTRL:     zdm_reg     <= wr_mrg[`OCC_B_ZDM];
                `OCC_A_OUT_EN:   out_en_reg  <= wr_mrg[9:0];
                `OCC_A_DIS_LVL:  dis_lvl_reg <= wr_mrg[9:0];
                `OCC_A_ASYNC:    async_reg   <= wr_mrg[9:0];
                `OCC_A_INPHASE:  inphase_reg <= wr_mrg[9:0];
                `OCC_A_XSEL:     xsel_reg    <= wr_mrg[29:0];
                `OCC_A_DRV_MODE: mode_reg    <= wr_mrg[9:0];
                `OCC_A_DRV_AMP:  amp_reg     <= wr_mrg[29:0];
                default: ;
            endcase
        end
    end

    // Fractional dividers modelled as phase accumulators
    logic [31:0] num_stage [`OCC_NDIV];
    occ_word_t   freq_word [`OCC_NDIV];
    occ_word_t   step_word [`OCC_NDIV];
    occ_word_t   phase_acc [`OCC_NDIV];
    logic [15:0] skew_stage [`OCC_NDIV];
    logic [3:0]  num_shift [`OCC_NDIV];
    logic [4:0]  div_clk;

    genvar d;
    generate
        for (d = 0; d < `OCC_NDIV; d++) begin : g_div
            wire wr_d   = wr_fire && div_hit && (div_idx == 3'(d));
            wire upd    = wr_d && (div_off == `OCC_O_NUM_UPD) && be[0] && wd[0];
            wire ctl_w  = wr_d && (div_off == `OCC_O_FREQ_CTL) && be[0];
            wire up_r   = up_edge[d] || (ctl_w && wd[0]);
            wire dn_r   = down_edge[d] || (ctl_w && wd[1]);
            logic [15:0] skew_act;

            assign div_clk[d] = phase_acc[d][43];

            always_ff @(posedge clk_sys) begin
                if (cfg_rst) begin
                    num_stage[d]  <= `OCC_NUM_RST;
                    num_shift[d]  <= `OCC_SHIFT_RST;
                    freq_word[d]  <= `OCC_FREQ_RST;
                    step_word[d]  <= 44'h000_0000_0000;
                    skew_stage[d] <= `OCC_SKEW_NV;
                    skew_act      <= `OCC_SKEW_NV;
                    phase_acc[d]  <= {`OCC_SKEW_NV, 28'h000_0000};
                end else begin
                    if (wr_d) begin
                        case (div_off)
                            `OCC_O_NUM:     num_stage[d]  <= wr_mrg;
                            `OCC_O_SKEW:    skew_stage[d] <= wr_mrg[15:0];
                            `OCC_O_SHIFT:   num_shift[d]  <= wr_mrg[3:0];
                            `OCC_O_STEP_LO:
                                step_word[d][31:0]  <= wr_mrg;
                            `OCC_O_STEP_HI:
                                step_word[d][43:32] <= wr_mrg[11:0];
                            default: ;
                        endcase
                    end
                    if (upd) begin
                        freq_word[d] <=
                            44'(num_stage[d]) << num_shift[d];
                    end else if (up_r && !dn_r) begin
                        freq_word[d] <= freq_word[d] + step_word[d];
                    end else if (dn_r && !up_r) begin
                        freq_word[d] <= freq_word[d] - step_word[d];
                    end
                    if (soft_reg) begin
                        skew_act     <= skew_stage[d];
                        phase_acc[d] <= {skew_stage[d], 28'h000_0000};
                    end else if (realign_evt) begin
                        phase_acc[d] <= {skew_act, 28'h000_0000};
                    end else begin
                        // Phase is continuous across word changes
                        phase_acc[d] <= phase_acc[d] + freq_word[d];
                    end
                end
            end
        end
    endgenerate

    assign div_freq_word_0 = freq_word[0];

    // Output stage
    logic [9:0] src_prev_reg;
    logic [9:0] gate_reg;
    logic [9:0] outp_reg;
    logic [9:0] outn_reg;
    logic [9:0] lp_reg;
    logic [29:0] amp_out_reg;
    logic        fb_ext_reg;

    genvar k;
    generate
        for (k = 0; k < `OCC_NOUT; k++) begin : g_out
            wire [2:0] sel  = xsel_reg[3*k +: 3];
            wire       src  = (sel < 3'h5) ? div_clk[sel] : 1'b0;
            wire       want = !oe_n_lvl && out_en_reg[k];
            // Period ends when the source falls; a synchronous gate changes only there
            wire       edge_ok = src_prev_reg[k] && !src;
            wire       gate_nx = async_reg[k] ? want :
                                 (edge_ok ? want : gate_reg[k]);
            wire       n_src   = inphase_reg[k] ? src : !src;

            always_ff @(posedge clk_sys) begin
                if (cfg_rst) begin
                    src_prev_reg[k] <= 1'b0;
                    gate_reg[k]     <= 1'b0;
                    outp_reg[k]     <= 1'b0;
                    outn_reg[k]     <= 1'b0;
                end else begin
                    src_prev_reg[k] <= src;
                    gate_reg[k]     <= gate_nx;
                    outp_reg[k]     <= gate_nx ? src : dis_lvl_reg[k];
                    outn_reg[k]     <= gate_nx ? n_src : dis_lvl_reg[k];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (cfg_rst) begin
            lp_reg      <= 10'h000;
            amp_out_reg <= `OCC_AMP_RST;
            fb_ext_reg  <= 1'b0;
        end else begin
            lp_reg      <= mode_reg;
            amp_out_reg <= amp_reg;
            fb_ext_reg  <= zdm_reg;
        end
    end

    assign out_p             = outp_reg;
    assign out_n             = outn_reg;
    assign drv_low_power     = lp_reg;
    assign drv_amplitude     = amp_out_reg;
    assign feedback_external = fb_ext_reg;

    // Read mux
    wire [31:0] status_w = {13'h0, ext_fb, pin_s2_reg[10], oe_n_lvl,
                            6'h0, gate_reg};
    wire [31:0] rd_glb =
        (avs_address == `OCC_A_CTRL)     ? {28'h0, zdm_reg, 3'h0} :
        (avs_address == `OCC_A_OUT_EN)   ? {22'h0, out_en_reg} :
        (avs_address == `OCC_A_DIS_LVL)  ? {22'h0, dis_lvl_reg} :
        (avs_address == `OCC_A_ASYNC)    ? {22'h0, async_reg} :
        (avs_address == `OCC_A_INPHASE)  ? {22'h0, inphase_reg} :
        (avs_address == `OCC_A_STATUS)   ? status_w :
        (avs_address == `OCC_A_XSEL)     ? {2'h0, xsel_reg} :
        (avs_address == `OCC_A_DRV_MODE) ? {22'h0, mode_reg} :
        (avs_address == `OCC_A_DRV_AMP)  ? {2'h0, amp_reg} :
        32'h0000_0000;
    wire [2:0] ri = div_hit ? div_idx : 3'h0;
    wire [31:0] rd_div =
        (div_off == `OCC_O_NUM)     ? num_stage[ri] :
        (div_off == `OCC_O_STEP_LO) ? step_word[ri][31:0] :
        (div_off == `OCC_O_STEP_HI) ? {20'h0, step_word[ri][43:32]} :
        (div_off == `OCC_O_SKEW)    ? {16'h0, skew_stage[ri]} :
        (div_off == `OCC_O_SHIFT)   ? {28'h0, num_shift[ri]} :
        (div_off == `OCC_O_FREQ_RB) ? freq_word[ri][31:0] :
        32'h0000_0000;

    assign rd_mux = avs_address[8] ? (div_hit ? rd_div : 32'h0000_0000)
                                   : rd_glb;

endmodule : occ_top

/* test/occ_clk_load.sv */
module occ_clk_load (
    // Clock
    input wire logic    clk_sys,
    // Observed clock and clear
    input wire logic    clr,
    input wire logic    level,
    // Shortest completed high pulse
    output logic [15:0] min_high
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        armed_reg;
    logic [15:0] run_reg;
    // Arms only after a low, so a clear in mid-pulse shows no false runt
    always_ff @(posedge clk_sys) begin
        if (clr) begin
            armed_reg <= 1'b0;
            run_reg   <= 16'h0000;
            min_high  <= 16'hFFFF;
        end else if (!level) begin
            armed_reg <= 1'b1;
            run_reg   <= 16'h0000;
            if (armed_reg && run_reg != 16'h0000 &&
                run_reg < min_high) begin
                min_high <= run_reg;
            end
        end else if (armed_reg) begin
            run_reg <= run_reg + 16'h0001;
        end
    end
endmodule : occ_clk_load

/* test/occ_props.sv */
`include "occ_defines.svh"
module occ_props (
    // Clock and reset
    input wire logic               clk_sys,
    input wire logic               reset,
    // Register bus
    input wire logic [8:0]         avs_address,
    input wire logic               avs_read,
    input wire logic               avs_write,
    input wire logic [31:0]        avs_writedata,
    input wire logic [31:0]        avs_readdata,
    input wire logic               avs_waitrequest,
    // Pins
    input wire logic               oe_n,
    input wire logic [4:0]         freq_up_request,
    input wire logic [4:0]         freq_down_request,
    // Outputs
    input wire logic [9:0]         out_p,
    input wire logic [9:0]         out_n,
    input wire logic [9:0]         drv_low_power,
    input wire logic [29:0]        drv_amplitude,
    input wire logic               feedback_external,
    input wire occ_pkg::occ_word_t div_freq_word_0
);
    timeunit 1ns;
    timeprecision 1ps;
    import occ_pkg::*;
    // Longer than the slowest source period, so the gate has surely closed
    localparam int OE_SETTLE = 1100;
    logic        wr_done, wr_ctrl, wr_drv, wr_div0, hard_req, rise0;
    logic        up_q_reg, dn_q_reg;
    logic [2:0]  cause_reg, cause_next;
    logic [10:0] oe_cnt_reg, oe_cnt_next;
    assign wr_done  = avs_write && !avs_waitrequest;
    assign wr_ctrl  = wr_done && avs_address == `OCC_A_CTRL;
    assign wr_drv   = wr_done && (avs_address == `OCC_A_DRV_MODE ||
                                  avs_address == `OCC_A_DRV_AMP);
    assign wr_div0  = wr_done && avs_address[8:5] == 4'h8;
    assign hard_req = wr_ctrl && avs_writedata[`OCC_B_HARD];
    assign rise0    = (freq_up_request[0] && !up_q_reg) ||
                      (freq_down_request[0] && !dn_q_reg);
    assign cause_next  = (wr_div0 || wr_ctrl || rise0) ? 3'h6 :
                         (cause_reg != 3'h0) ? cause_reg - 3'h1 : 3'h0;
    assign oe_cnt_next = !oe_n ? 11'h000 :
                         (oe_cnt_reg == OE_SETTLE) ? oe_cnt_reg :
                         oe_cnt_reg + 11'h001;
    always_ff @(posedge clk_sys) begin
        up_q_reg   <= freq_up_request[0];
        dn_q_reg   <= freq_down_request[0];
        cause_reg  <= reset ? 3'h0 : cause_next;
        oe_cnt_reg <= reset ? 11'h000 : oe_cnt_next;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_req; $rose(avs_read || avs_write); endsequence
    sequence s_ans; !avs_waitrequest ##1 avs_waitrequest; endsequence
    property p_access; s_req |=> s_ans; endproperty
    property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    property p_rd_zero;
        avs_waitrequest |-> avs_readdata == 32'h0000_0000;
    endproperty
    property p_rst_state;
        $fell(reset) |-> avs_waitrequest && out_p == 10'h000 &&
                         out_n == 10'h000;
    endproperty
    property p_oe_quiet;
        oe_cnt_reg == OE_SETTLE |-> $stable(out_p) && $stable(out_n);
    endproperty
    property p_drv_cause;
        ($changed(drv_low_power) || $changed(drv_amplitude)) |->
            $past(wr_drv) || $past(wr_drv, 2) || $past(hard_req, 2) ||
            $past(hard_req, 3) || $past(reset) || $past(reset, 2);
    endproperty
    property p_fb_cause;
        $changed(feedback_external) |->
            $past(wr_ctrl) || $past(wr_ctrl, 2) || $past(wr_ctrl, 3);
    endproperty
    property p_freq_cause;
        $changed(div_freq_word_0) |-> cause_reg != 3'h0;
    endproperty
    property p_hard;
        hard_req |-> ##[1:3] div_freq_word_0 == `OCC_FREQ_RST;
    endproperty
    a_access: assert property (p_access)
        else $error("late bus answer");
    a_wait_one: assert property (p_wait_one)
        else $error("long waitrequest low");
    a_rd_zero: assert property (p_rd_zero)
        else $error("readdata not zero when idle");
    a_rst_state: assert property (p_rst_state)
        else $error("not idle after reset");
    a_oe_quiet: assert property (p_oe_quiet)
        else $error("output moved while disabled");
    a_drv_cause: assert property (p_drv_cause)
        else $error("driver change without write");
    a_fb_cause: assert property (p_fb_cause)
        else $error("feedback change without write");
    a_freq_cause: assert property (p_freq_cause)
        else $error("frequency change unrequested");
    a_hard: assert property (p_hard)
        else $error("hard reset kept frequency");
endmodule : occ_props

bind occ_top occ_props i_props (
    .clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .oe_n, .freq_up_request,
    .freq_down_request, .out_p, .out_n, .drv_low_power, .drv_amplitude,
    .feedback_external, .div_freq_word_0
);

/* test/output_clock_control_tb.sv */
`include "occ_defines.svh"
module output_clock_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import occ_pkg::*;
    localparam logic [43:0] F_UP = `OCC_FREQ_RST + 44'h010;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic [8:0]  avs_address = 9'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        oe_n = 1'b0;
    logic        sync_pin = 1'b0;
    logic [4:0]  freq_up_request = 5'h00;
    logic [4:0]  freq_down_request = 5'h00;
    logic        external_feedback_input = 1'b0;
    logic [9:0]  out_p, out_n, drv_low_power;
    logic [29:0] drv_amplitude;
    logic        feedback_external;
    occ_word_t   div_freq_word_0;
    logic        load_clr = 1'b0;
    logic [15:0] min_high;
    logic [31:0] rd;
    int          err_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          d;
    occ_top i_dut (.clk_sys, .reset, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .oe_n, .sync_pin, .freq_up_request, .freq_down_request,
        .external_feedback_input, .out_p, .out_n, .drv_low_power,
        .drv_amplitude, .feedback_external, .div_freq_word_0);
    occ_clk_load i_load (.clk_sys, .clr(load_clr), .level(out_p[3]),
        .min_high);
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end
    task final_report;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task ticks(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : ticks
    task bus(input logic w, input logic [8:0] a, input logic [31:0] v,
             input logic [3:0] be);
        @(posedge clk_sys);
        avs_address    <= a;
        avs_writedata  <= v;
        avs_byteenable <= be;
        avs_write      <= w;
        avs_read       <= !w;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus
    task wr(input logic [8:0] a, input logic [31:0] v);
        bus(1'b1, a, v, 4'hF);
    endtask : wr
    task rchk(input logic [8:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
        check(rd, e);
    endtask : rchk
    // Cycle distance from a rise of output 0 to one of output 1, modulo 16
    task phase(output int dd);
        int a;
        int b;
        logic [1:0] pv;
        a = -1;
        b = -1;
        pv = out_p[1:0];
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_sys);
            if (a < 0 && out_p[0] === 1'b1 && pv[0] === 1'b0) a = i;
            if (b < 0 && out_p[1] === 1'b1 && pv[1] === 1'b0) b = i;
            pv = out_p[1:0];
        end
        dd = (a < 0 || b < 0) ? -1 : (b - a) & 15;
    endtask : phase
    initial begin
        ticks(6);
        reset <= 1'b0;
        ticks(2);
        rchk(`OCC_A_OUT_EN, 32'h0000_03FF);
        rchk(`OCC_A_ASYNC, 32'h0000_0000);
        rchk(`OCC_A_DRV_AMP, 32'h1249_2492);
        rchk(9'h118, 32'h0000_0004);
        wr(9'h024, 32'hFFFF_FFFF);
        rchk(9'h024, 32'h0000_0000);
        check(div_freq_word_0, `OCC_FREQ_RST);
        wr(`OCC_A_DRV_MODE, 32'h0000_02AA);
        wr(`OCC_A_DRV_AMP, 32'h3FFF_FFFF);
        ticks(3);
        check(drv_low_power, 10'h2AA);
        check(drv_amplitude, 30'h3FFF_FFFF);
        wr(9'h108, 32'h0000_0010);
        wr(9'h12C, 32'hFFFF_F123);
        rchk(9'h12C, 32'h0000_0123);
        wr(9'h128, 32'h0000_1000);
        for (int k = 1; k <= 3; k++) begin
            wr(9'h114, k);
            ticks(3);
            check(div_freq_word_0, k == 1 ? F_UP : `OCC_FREQ_RST);
        end
        freq_up_request <= 5'h03;
        ticks(10);
        check(div_freq_word_0, F_UP);
        freq_up_request   <= 5'h00;
        freq_down_request <= 5'h01;
        ticks(10);
        check(div_freq_word_0, `OCC_FREQ_RST);
        freq_down_request <= 5'h00;
        wr(9'h100, 32'h1000_0000);
        wr(9'h118, 32'h0000_000C);
        ticks(3);
        check(div_freq_word_0, `OCC_FREQ_RST);
        wr(9'h104, 32'h0000_0001);
        ticks(3);
        check(div_freq_word_0, 44'h100_0000_0000);
        bus(1'b1, 9'h100, 32'hFFFF_FFFF, 4'h1);
        rchk(9'h100, 32'h1000_00FF);
        wr(9'h120, 32'h1000_0000);
        wr(9'h138, 32'h0000_000C);
        wr(9'h124, 32'h0000_0001);
        wr(`OCC_A_XSEL, 32'h0000_0148);
        rchk(`OCC_A_XSEL, 32'h0000_0148);
        sync_pin <= 1'b1;
        ticks(10);
        phase(d);
        check(d, 0);
        sync_pin <= 1'b0;
        wr(9'h130, 32'h0000_4000);
        wr(`OCC_A_CTRL, 32'h0000_0004);
        ticks(5);
        phase(d);
        check(d, 0);
        wr(`OCC_A_CTRL, 32'h0000_0001);
        ticks(5);
        phase(d);
        check(d, 12);
        for (int k = 0; k < 8; k++) begin
            if (k == 4) wr(`OCC_A_INPHASE, 32'h0000_0001);
            ticks(3);
            check(out_n[0], k < 4 ? !out_p[0] : out_p[0]);
        end
        load_clr <= 1'b1;
        ticks(1);
        load_clr <= 1'b0;
        ticks(20);
        wr(`OCC_A_OUT_EN, 32'h0000_03F7);
        ticks(40);
        check(min_high, 16'h0008);
        check(out_p[3], 1'b0);
        wr(`OCC_A_ASYNC, 32'h0000_0004);
        wr(`OCC_A_OUT_EN, 32'h0000_03F3);
        ticks(2);
        rchk(`OCC_A_STATUS, 32'h0000_03F3);
        wr(`OCC_A_DIS_LVL, 32'h0000_0008);
        ticks(20);
        check({out_p[3], out_n[3]}, 2'b11);
        oe_n <= 1'b1;
        ticks(1150);
        rchk(`OCC_A_STATUS, 32'h0001_0000);
        check(out_p, 10'h008);
        oe_n <= 1'b0;
        ticks(40);
        rchk(`OCC_A_STATUS, 32'h0000_03F3);
        wr(`OCC_A_CTRL, 32'h0000_0008);
        external_feedback_input <= 1'b1;
        ticks(4);
        check(feedback_external, 1'b1);
        rchk(`OCC_A_CTRL, 32'h0000_0008);
        bus(1'b0, `OCC_A_STATUS, 32'h0000_0000, 4'hF);
        check(rd[18], 1'b1);
        wr(`OCC_A_CTRL, 32'h0000_0002);
        ticks(4);
        check(div_freq_word_0, `OCC_FREQ_RST);
        rchk(9'h130, 32'h0000_0000);
        rchk(`OCC_A_OUT_EN, 32'h0000_03FF);
        check(feedback_external, 1'b0);
        reset <= 1'b1;
        ticks(3);
        reset <= 1'b0;
        ticks(2);
        check({out_p, out_n}, 20'h0_0000);
        final_report();
    end
endmodule : output_clock_control_tb
